// ### dicp_calc.sv
// Calculate function and frequency offset datapath, purely combinational.
// Assumes operand values and settings are already on the core clock.
`timescale 1ns/1ns
`default_nettype none
`include "dicp_regs.svh"

module dicp_calc #(
    parameter int DW = 16
) (
    // Operand sources
    input wire logic [DW-1:0] operator_val_i,
    input wire logic [DW-1:0] pot_val_i,
    input wire logic [DW-1:0] voltage_val_i,
    input wire logic [DW-1:0] current_val_i,
    input wire logic [DW-1:0] network_val_i,
    // Controls
    input wire logic [2:0] src_a_i,
    input wire logic [2:0] src_b_i,
    input wire logic [1:0] op_i,
    // Offset
    input wire logic [DW-1:0] freq_set_i,
    input wire logic [DW-1:0] ofs_val_i,
    input wire logic ofs_minus_i,
    input wire logic ofs_active_i,
    // Results
    output logic signed [2*DW-1:0] calc_o,
    output logic [DW-1:0] freq_o
);

    logic [DW-1:0] opa;
    logic [DW-1:0] opb;
    logic [DW:0] fsum;

    function automatic logic [DW-1:0] pick(input logic [2:0] sel,
                                           input logic [DW-1:0] v0, v1, v2, v3, v4);
        logic [DW-1:0] r;
        r = v0;
        unique case (dicp_pkg::dicp_src_t'(sel))
            dicp_pkg::DICP_SRC_OPERATOR: r = v0;
            dicp_pkg::DICP_SRC_POT: r = v1;
            dicp_pkg::DICP_SRC_VOLTAGE: r = v2;
            dicp_pkg::DICP_SRC_CURRENT: r = v3;
            dicp_pkg::DICP_SRC_NETWORK: r = v4;
            default: r = v0;
        endcase
        return r;
    endfunction : pick

    // ----------------------------------------
    // Operand selection and operation
    // ----------------------------------------
    always_comb begin
        opa = pick(src_a_i, operator_val_i, pot_val_i, voltage_val_i, current_val_i,
                   network_val_i); // see R4
        opb = pick(src_b_i, operator_val_i, pot_val_i, voltage_val_i, current_val_i,
                   network_val_i); // see R5
        calc_o = '0;
        unique case (dicp_pkg::dicp_op_t'(op_i))
            dicp_pkg::DICP_OP_ADD: calc_o = signed'({{DW{1'b0}}, opa} + {{DW{1'b0}}, opb}); // see R6
            dicp_pkg::DICP_OP_SUB: calc_o = signed'({{DW{1'b0}}, opa} - {{DW{1'b0}}, opb}); // see R6
            dicp_pkg::DICP_OP_MUL: calc_o = signed'({{DW{1'b0}}, opa} * {{DW{1'b0}}, opb}); // see R6
            default: calc_o = '0;
        endcase
    end

    // ----------------------------------------
    // Offset, saturating at zero and full scale
    // ----------------------------------------
    always_comb begin
        fsum = {1'b0, freq_set_i};
        freq_o = freq_set_i;
        if (ofs_active_i) begin // see R7
            if (ofs_minus_i) begin // see R8
                freq_o = (ofs_val_i > freq_set_i) ? '0 : freq_set_i - ofs_val_i;
            end else begin
                fsum = {1'b0, freq_set_i} + {1'b0, ofs_val_i};
                freq_o = (fsum > {1'b0, DW'(`DICP_MAX_FREQ)}) ? DW'(`DICP_MAX_FREQ) :
                         fsum[DW-1:0];
            end
        end
    end

endmodule : dicp_calc
`default_nettype wire

// ### dicp_master.sv
// Network master model: one holding register access per call.
// Assumes the bank answers on the cycle after the strobe edge.
`timescale 1ns/1ns
`default_nettype none
module dicp_master (
    // Bank side
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic err_i,
    input wire logic [15:0] rdata_i,
    output logic [15:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial {wr_o, rd_o, addr_o, wdata_o} = 34'h0;
    // Idle bus shows inverted data so stale values never look valid
    task automatic acc(input logic w, input logic [15:0] a, d,
                       output logic [17:0] r);
        @(posedge clk_i);
        {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, d};
        @(posedge clk_i);
        {wr_o, rd_o, addr_o, wdata_o} <= {2'b00, ~a, ~d};
        @(posedge clk_i);
        r = {ack_i, err_i, rdata_i};
    endtask : acc
endmodule : dicp_master
`default_nettype wire

// ### dicp_pkg.sv
// Types shared by the drive parameter bank.
// Assumes compilation before the design modules.
package dicp_pkg;

    // ----------------------------------------
    // Operand sources
    // ----------------------------------------
    typedef enum logic [2:0] {
        DICP_SRC_OPERATOR = 3'h0,
        DICP_SRC_POT = 3'h1,
        DICP_SRC_VOLTAGE = 3'h2,
        DICP_SRC_CURRENT = 3'h3,
        DICP_SRC_NETWORK = 3'h4
    } dicp_src_t;

    // ----------------------------------------
    // Calculate operations
    // ----------------------------------------
    typedef enum logic [1:0] {
        DICP_OP_ADD = 2'h0,
        DICP_OP_SUB = 2'h1,
        DICP_OP_MUL = 2'h2
    } dicp_op_t;

    // ----------------------------------------
    // Register index after address decode
    // ----------------------------------------
    typedef enum logic [4:0] {
        DICP_IDX_ACC2_HI = 5'h00,
        DICP_IDX_ACC2_LO = 5'h01,
        DICP_IDX_DEC2_HI = 5'h02,
        DICP_IDX_DEC2_LO = 5'h03,
        DICP_IDX_CUR_START_PT = 5'h04,
        DICP_IDX_CUR_END_PT = 5'h05,
        DICP_IDX_CUR_FSEL = 5'h06,
        DICP_IDX_OPA_SRC = 5'h07,
        DICP_IDX_OPB_SRC = 5'h08,
        DICP_IDX_CALC_OP = 5'h09,
        DICP_IDX_OFS_VAL = 5'h0A,
        DICP_IDX_OFS_DIR = 5'h0B,
        DICP_IDX_POT_START_F = 5'h0C,
        DICP_IDX_POT_END_F = 5'h0D,
        DICP_IDX_POT_START_PT = 5'h0E,
        DICP_IDX_POT_END_PT = 5'h0F,
        DICP_IDX_POT_FEN = 5'h10,
        DICP_IDX_NONE = 5'h1F
    } dicp_idx_t;

endpackage : dicp_pkg

// ### dicp_regs.svh
// Offsets, limits and reset values of the parameter bank.
// Assumes inclusion by bare name from the design files.
`ifndef DICP_REGS_SVH
`define DICP_REGS_SVH

// ----------
// Holding register offsets
// ----------
`define DICP_OFS_ACC2_HI 16'h1074
`define DICP_OFS_ACC2_LO 16'h1075
`define DICP_OFS_DEC2_HI 16'h1076
`define DICP_OFS_DEC2_LO 16'h1077
`define DICP_OFS_CUR_START_PT 16'h1083
`define DICP_OFS_CUR_END_PT 16'h1084
`define DICP_OFS_CUR_FSEL 16'h1085
`define DICP_OFS_OPA_SRC 16'h108E
`define DICP_OFS_OPB_SRC 16'h108F
`define DICP_OFS_CALC_OP 16'h1090
`define DICP_OFS_OFS_VAL 16'h1091
`define DICP_OFS_OFS_DIR 16'h1093
`define DICP_OFS_POT_START_F 16'h1095
`define DICP_OFS_POT_END_F 16'h1097
`define DICP_OFS_POT_START_PT 16'h1098
`define DICP_OFS_POT_END_PT 16'h1099
`define DICP_OFS_POT_FEN 16'h109A

// ----------
// Value limits
// ----------
`define DICP_MAX_PERCENT 16'h0064
`define DICP_MAX_FREQ 16'h0FA0
`define DICP_MAX_BINARY 16'h0001
`define DICP_MAX_SOURCE 16'h0004
`define DICP_MAX_CALC_OP 16'h0002
`define DICP_MIN_TIME 32'h0000_0001
`define DICP_MAX_TIME 32'h0004_93E0
`define DICP_TIME_COARSE 32'h0000_2710
`define DICP_TIME_DIGIT 32'h0000_000A

// ----------
// Reset values
// ----------
`define DICP_RST_ZERO 16'h0000
`define DICP_RST_PERCENT_END 16'h0064
`define DICP_RST_TIME 32'h0000_03E8

`endif

// ### dicp_top.sv
// Holding register bank for analog range scaling, calculate and offset functions.
// Assumes a network slave front end that presents one register access per strobe.
`timescale 1ns/1ns
`default_nettype none
`include "dicp_regs.svh"

// Overview of operation
// R1 - Hold current-input start point, 0 to 100 percent.
// R2 - Hold current-input end point, 0 to 100 percent.
// R3 - Current-input start selector: 00 uses start frequency, 01 uses 0 Hz.
// R4 - Operand A source: operator, pot, voltage, current or network, codes 0-4.
// R5 - Operand B source uses the same 0-4 source mapping.
// R6 - Calculate gives A+B, A-B or A*B for codes 00, 01, 02.
// R7 - Offset applies to output frequency while request terminal is active.
// R8 - Offset direction: 00 adds, 01 subtracts the offset.
// R9 - Hold pot start and end frequency, 0 to 4000 in 0.1 Hz.
// R10 - Hold pot start and end point, 0 to 100 percent.
// R11 - Second-stage times at 10000 or more drop the hundredths digit.
// R12 - Out-of-range writes are rejected; previous contents are kept.
module dicp_top #(
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Holding register access
    input wire logic [15:0] reg_addr_i,
    input wire logic [DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DW-1:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_err_o,
    // Operand sources
    input wire logic [DW-1:0] operator_val_i,
    input wire logic [DW-1:0] pot_val_i,
    input wire logic [DW-1:0] voltage_val_i,
    input wire logic [DW-1:0] current_val_i,
    input wire logic [DW-1:0] network_val_i,
    // Frequency path
    input wire logic [DW-1:0] freq_set_i,
    input wire logic offset_req_i,
    output logic [DW-1:0] freq_out_o,
    output logic signed [2*DW-1:0] calc_result_o,
    // Settings to the scaling logic
    output logic [DW-1:0] current_in_start_point_o,
    output logic [DW-1:0] current_in_end_point_o,
    output logic current_in_zero_below_start_o,
    output logic [DW-1:0] pot_start_frequency_o,
    output logic [DW-1:0] pot_end_frequency_o,
    output logic [DW-1:0] pot_start_point_o,
    output logic [DW-1:0] pot_end_point_o,
    output logic pot_start_freq_enable_o,
    output logic [31:0] second_accel_time_o,
    output logic [31:0] second_decel_time_o
);

    // ----------------------------------------
    // Reset release and pin synchroniser
    // ----------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;
    logic ofs_meta_r;
    logic ofs_sync_r;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire logic rstn = rst_sync_r;

    // Terminal is asynchronous to the core clock
    always_ff @(posedge core_clk_i or negedge rstn) begin
        if (!rstn) begin
            ofs_meta_r <= 1'b0;
            ofs_sync_r <= 1'b0;
        end else begin
            ofs_meta_r <= offset_req_i;
            ofs_sync_r <= ofs_meta_r;
        end
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [DW-1:0] cur_start_pt_r;
    logic [DW-1:0] cur_end_pt_r;
    logic [DW-1:0] cur_fsel_r;
    logic [DW-1:0] opa_src_r;
    logic [DW-1:0] opb_src_r;
    logic [DW-1:0] calc_op_r;
    logic [DW-1:0] ofs_val_r;
    logic [DW-1:0] ofs_dir_r;
    logic [DW-1:0] pot_start_f_r;
    logic [DW-1:0] pot_end_f_r;
    logic [DW-1:0] pot_start_pt_r;
    logic [DW-1:0] pot_end_pt_r;
    logic [DW-1:0] pot_fen_r;
    logic [31:0] acc2_r;
    logic [31:0] dec2_r;

    // ----------------------------------------
    // Address decode and range check
    // ----------------------------------------
    function automatic dicp_pkg::dicp_idx_t decode(input logic [15:0] a);
        dicp_pkg::dicp_idx_t r;
        r = dicp_pkg::DICP_IDX_NONE;
        case (a)
            `DICP_OFS_ACC2_HI: r = dicp_pkg::DICP_IDX_ACC2_HI;
            `DICP_OFS_ACC2_LO: r = dicp_pkg::DICP_IDX_ACC2_LO;
            `DICP_OFS_DEC2_HI: r = dicp_pkg::DICP_IDX_DEC2_HI;
            `DICP_OFS_DEC2_LO: r = dicp_pkg::DICP_IDX_DEC2_LO;
            `DICP_OFS_CUR_START_PT: r = dicp_pkg::DICP_IDX_CUR_START_PT;
            `DICP_OFS_CUR_END_PT: r = dicp_pkg::DICP_IDX_CUR_END_PT;
            `DICP_OFS_CUR_FSEL: r = dicp_pkg::DICP_IDX_CUR_FSEL;
            `DICP_OFS_OPA_SRC: r = dicp_pkg::DICP_IDX_OPA_SRC;
            `DICP_OFS_OPB_SRC: r = dicp_pkg::DICP_IDX_OPB_SRC;
            `DICP_OFS_CALC_OP: r = dicp_pkg::DICP_IDX_CALC_OP;
            `DICP_OFS_OFS_VAL: r = dicp_pkg::DICP_IDX_OFS_VAL;
            `DICP_OFS_OFS_DIR: r = dicp_pkg::DICP_IDX_OFS_DIR;
            `DICP_OFS_POT_START_F: r = dicp_pkg::DICP_IDX_POT_START_F;
            `DICP_OFS_POT_END_F: r = dicp_pkg::DICP_IDX_POT_END_F;
            `DICP_OFS_POT_START_PT: r = dicp_pkg::DICP_IDX_POT_START_PT;
            `DICP_OFS_POT_END_PT: r = dicp_pkg::DICP_IDX_POT_END_PT;
            `DICP_OFS_POT_FEN: r = dicp_pkg::DICP_IDX_POT_FEN;
            default: r = dicp_pkg::DICP_IDX_NONE;
        endcase
        return r;
    endfunction : decode

    function automatic logic time_ok(input logic [31:0] t);
        return (t >= `DICP_MIN_TIME) && (t <= `DICP_MAX_TIME);
    endfunction : time_ok

    // Hundredths digit dropped on long times
    function automatic logic [31:0] time_eff(input logic [31:0] t);
        return (t >= `DICP_TIME_COARSE) ? t - (t % `DICP_TIME_DIGIT) : t; // see R11
    endfunction : time_eff

    dicp_pkg::dicp_idx_t idx;
    logic in_range;
    logic [31:0] acc2_hi_new;
    logic [31:0] acc2_lo_new;
    logic [31:0] dec2_hi_new;
    logic [31:0] dec2_lo_new;

    always_comb begin
        idx = decode(reg_addr_i);
        acc2_hi_new = {reg_wdata_i, acc2_r[15:0]};
        acc2_lo_new = {acc2_r[31:16], reg_wdata_i};
        dec2_hi_new = {reg_wdata_i, dec2_r[15:0]};
        dec2_lo_new = {dec2_r[31:16], reg_wdata_i};
        in_range = 1'b0;
        unique case (idx)
            dicp_pkg::DICP_IDX_ACC2_HI: in_range = time_ok(acc2_hi_new);
            dicp_pkg::DICP_IDX_ACC2_LO: in_range = time_ok(acc2_lo_new);
            dicp_pkg::DICP_IDX_DEC2_HI: in_range = time_ok(dec2_hi_new);
            dicp_pkg::DICP_IDX_DEC2_LO: in_range = time_ok(dec2_lo_new);
            dicp_pkg::DICP_IDX_CUR_START_PT,
            dicp_pkg::DICP_IDX_CUR_END_PT,
            dicp_pkg::DICP_IDX_POT_START_PT,
            dicp_pkg::DICP_IDX_POT_END_PT: in_range = reg_wdata_i <= `DICP_MAX_PERCENT;
            dicp_pkg::DICP_IDX_CUR_FSEL,
            dicp_pkg::DICP_IDX_OFS_DIR,
            dicp_pkg::DICP_IDX_POT_FEN: in_range = reg_wdata_i <= `DICP_MAX_BINARY;
            dicp_pkg::DICP_IDX_OPA_SRC,
            dicp_pkg::DICP_IDX_OPB_SRC: in_range = reg_wdata_i <= `DICP_MAX_SOURCE;
            dicp_pkg::DICP_IDX_CALC_OP: in_range = reg_wdata_i <= `DICP_MAX_CALC_OP;
            dicp_pkg::DICP_IDX_OFS_VAL,
            dicp_pkg::DICP_IDX_POT_START_F,
            dicp_pkg::DICP_IDX_POT_END_F: in_range = reg_wdata_i <= `DICP_MAX_FREQ;
            default: in_range = 1'b0;
        endcase
    end

    wire logic wr_ok = reg_wr_i && in_range; // see R12

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn) begin
        if (!rstn) begin
            cur_start_pt_r <= `DICP_RST_ZERO;
            cur_end_pt_r <= `DICP_RST_PERCENT_END;
            cur_fsel_r <= `DICP_RST_ZERO;
            opa_src_r <= `DICP_RST_ZERO;
            opb_src_r <= `DICP_RST_ZERO;
            calc_op_r <= `DICP_RST_ZERO;
            ofs_val_r <= `DICP_RST_ZERO;
            ofs_dir_r <= `DICP_RST_ZERO;
            pot_start_f_r <= `DICP_RST_ZERO;
            pot_end_f_r <= `DICP_RST_ZERO;
            pot_start_pt_r <= `DICP_RST_ZERO;
            pot_end_pt_r <= `DICP_RST_PERCENT_END;
            pot_fen_r <= `DICP_RST_ZERO;
            acc2_r <= `DICP_RST_TIME;
            dec2_r <= `DICP_RST_TIME;
        end else if (wr_ok) begin
            unique case (idx)
                dicp_pkg::DICP_IDX_ACC2_HI: acc2_r <= acc2_hi_new;
                dicp_pkg::DICP_IDX_ACC2_LO: acc2_r <= acc2_lo_new;
                dicp_pkg::DICP_IDX_DEC2_HI: dec2_r <= dec2_hi_new;
                dicp_pkg::DICP_IDX_DEC2_LO: dec2_r <= dec2_lo_new;
                dicp_pkg::DICP_IDX_CUR_START_PT: cur_start_pt_r <= reg_wdata_i; // see R1
                dicp_pkg::DICP_IDX_CUR_END_PT: cur_end_pt_r <= reg_wdata_i; // see R2
                dicp_pkg::DICP_IDX_CUR_FSEL: cur_fsel_r <= reg_wdata_i; // see R3
                dicp_pkg::DICP_IDX_OPA_SRC: opa_src_r <= reg_wdata_i; // see R4
                dicp_pkg::DICP_IDX_OPB_SRC: opb_src_r <= reg_wdata_i; // see R5
                dicp_pkg::DICP_IDX_CALC_OP: calc_op_r <= reg_wdata_i; // see R6
                dicp_pkg::DICP_IDX_OFS_VAL: ofs_val_r <= reg_wdata_i; // see R7
                dicp_pkg::DICP_IDX_OFS_DIR: ofs_dir_r <= reg_wdata_i; // see R8
                dicp_pkg::DICP_IDX_POT_START_F: pot_start_f_r <= reg_wdata_i; // see R9
                dicp_pkg::DICP_IDX_POT_END_F: pot_end_f_r <= reg_wdata_i; // see R9
                dicp_pkg::DICP_IDX_POT_START_PT: pot_start_pt_r <= reg_wdata_i; // see R10
                dicp_pkg::DICP_IDX_POT_END_PT: pot_end_pt_r <= reg_wdata_i; // see R10
                dicp_pkg::DICP_IDX_POT_FEN: pot_fen_r <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Read data and access answer
    // ----------------------------------------
    logic [DW-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        unique case (idx)
            dicp_pkg::DICP_IDX_ACC2_HI: rd_mux = acc2_r[31:16];
            dicp_pkg::DICP_IDX_ACC2_LO: rd_mux = acc2_r[15:0];
            dicp_pkg::DICP_IDX_DEC2_HI: rd_mux = dec2_r[31:16];
            dicp_pkg::DICP_IDX_DEC2_LO: rd_mux = dec2_r[15:0];
            dicp_pkg::DICP_IDX_CUR_START_PT: rd_mux = cur_start_pt_r;
            dicp_pkg::DICP_IDX_CUR_END_PT: rd_mux = cur_end_pt_r;
            dicp_pkg::DICP_IDX_CUR_FSEL: rd_mux = cur_fsel_r;
            dicp_pkg::DICP_IDX_OPA_SRC: rd_mux = opa_src_r;
            dicp_pkg::DICP_IDX_OPB_SRC: rd_mux = opb_src_r;
            dicp_pkg::DICP_IDX_CALC_OP: rd_mux = calc_op_r;
            dicp_pkg::DICP_IDX_OFS_VAL: rd_mux = ofs_val_r;
            dicp_pkg::DICP_IDX_OFS_DIR: rd_mux = ofs_dir_r;
            dicp_pkg::DICP_IDX_POT_START_F: rd_mux = pot_start_f_r;
            dicp_pkg::DICP_IDX_POT_END_F: rd_mux = pot_end_f_r;
            dicp_pkg::DICP_IDX_POT_START_PT: rd_mux = pot_start_pt_r;
            dicp_pkg::DICP_IDX_POT_END_PT: rd_mux = pot_end_pt_r;
            dicp_pkg::DICP_IDX_POT_FEN: rd_mux = pot_fen_r;
            default: rd_mux = '0;
        endcase
    end

    // Write wins if both strobes arrive together
    always_ff @(posedge core_clk_i or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_o <= '0;
            reg_ack_o <= 1'b0;
            reg_err_o <= 1'b0;
        end else begin
            reg_ack_o <= wr_ok || (reg_rd_i && !reg_wr_i &&
                                   idx != dicp_pkg::DICP_IDX_NONE);
            reg_err_o <= (reg_wr_i && !in_range) || // see R12
                         (reg_rd_i && !reg_wr_i && idx == dicp_pkg::DICP_IDX_NONE);
            if (reg_rd_i && !reg_wr_i) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    // ----------------------------------------
    // Calculate and offset datapath
    // ----------------------------------------
    logic signed [2*DW-1:0] calc_val;
    logic [DW-1:0] freq_val;

    dicp_calc #(
        .DW(DW)
    ) u_calc (
        .operator_val_i(operator_val_i),
        .pot_val_i(pot_val_i),
        .voltage_val_i(voltage_val_i),
        .current_val_i(current_val_i),
        .network_val_i(network_val_i),
        .src_a_i(opa_src_r[2:0]),
        .src_b_i(opb_src_r[2:0]),
        .op_i(calc_op_r[1:0]),
        .freq_set_i(freq_set_i),
        .ofs_val_i(ofs_val_r),
        .ofs_minus_i(ofs_dir_r[0]),
        .ofs_active_i(ofs_sync_r),
        .calc_o(calc_val),
        .freq_o(freq_val)
    );

    always_ff @(posedge core_clk_i or negedge rstn) begin
        if (!rstn) begin
            calc_result_o <= '0;
            freq_out_o <= '0;
        end else begin
            calc_result_o <= calc_val; // see R6
            freq_out_o <= freq_val; // see R7
        end
    end

    // ----------------------------------------
    // Settings presented to the scaling logic
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn) begin
        if (!rstn) begin
            current_in_start_point_o <= `DICP_RST_ZERO;
            current_in_end_point_o <= `DICP_RST_PERCENT_END;
            current_in_zero_below_start_o <= 1'b0;
            pot_start_frequency_o <= `DICP_RST_ZERO;
            pot_end_frequency_o <= `DICP_RST_ZERO;
            pot_start_point_o <= `DICP_RST_ZERO;
            pot_end_point_o <= `DICP_RST_PERCENT_END;
            pot_start_freq_enable_o <= 1'b0;
            second_accel_time_o <= `DICP_RST_TIME;
            second_decel_time_o <= `DICP_RST_TIME;
        end else begin
            current_in_start_point_o <= cur_start_pt_r;
            current_in_end_point_o <= cur_end_pt_r;
            current_in_zero_below_start_o <= cur_fsel_r[0]; // see R3
            pot_start_frequency_o <= pot_start_f_r;
            pot_end_frequency_o <= pot_end_f_r;
            pot_start_point_o <= pot_start_pt_r;
            pot_end_point_o <= pot_end_pt_r;
            pot_start_freq_enable_o <= pot_fen_r[0];
            second_accel_time_o <= time_eff(acc2_r); // see R11
            second_decel_time_o <= time_eff(dec2_r); // see R11
        end
    end

endmodule : dicp_top
`default_nettype wire

// ### dicp_top_sva.sv
// Checker for the bank's register port, limits and frequency path.
// Assumes a bind to dicp_top; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module dicp_top_sva #(
    parameter int DW = 16
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_ack_o,
    input wire logic reg_err_o,
    input wire logic [DW-1:0] freq_set_i,
    input wire logic offset_req_i,
    input wire logic [DW-1:0] freq_out_o,
    input wire logic [DW-1:0] current_in_end_point_o,
    input wire logic [31:0] second_accel_time_o
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_bad(a, m);
        reg_wr_i && reg_addr_i == a && reg_wdata_i > m;
    endsequence
    // Terminal idle long enough to flush the synchroniser
    sequence s_quiet;
        (!offset_req_i && $stable(freq_set_i) && freq_set_i <= 4000) [*4];
    endsequence
    AST_ANSWER: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o != reg_err_o)
        else $error("bad answer");
    AST_IDLE: assert property (!(reg_wr_i || reg_rd_i) |=> !(reg_ack_o || reg_err_o))
        else $error("stray answer");
    AST_PCT: assert property (s_bad(16'h1083, 100) |=> reg_err_o)
        else $error("bad percent taken");
    AST_SRCA: assert property (s_bad(16'h108E, 4) |=> reg_err_o)
        else $error("bad source A");
    AST_SRCB: assert property (s_bad(16'h108F, 4) |=> reg_err_o)
        else $error("bad source B");
    AST_OP: assert property (s_bad(16'h1090, 2) |=> reg_err_o)
        else $error("bad operation");
    AST_DIR: assert property (s_bad(16'h1093, 1) |=> reg_err_o)
        else $error("bad direction");
    AST_FRQ: assert property (s_bad(16'h1095, 4000) |=> reg_err_o)
        else $error("bad frequency");
    AST_END: assert property (reg_wr_i && reg_addr_i == 16'h1084 && reg_wdata_i <= 100
        |=> reg_ack_o ##1 current_in_end_point_o == $past(reg_wdata_i, 2))
        else $error("end point lost");
    AST_COARSE: assert property (second_accel_time_o >= 10000 |-> second_accel_time_o % 10 == 0)
        else $error("hundredths kept");
    AST_PLAIN: assert property (s_quiet |-> freq_out_o == freq_set_i)
        else $error("offset while idle");
endmodule : dicp_top_sva
bind dicp_top dicp_top_sva #(.DW(DW)) chk_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o),
    .freq_set_i(freq_set_i), .offset_req_i(offset_req_i), .freq_out_o(freq_out_o),
    .current_in_end_point_o(current_in_end_point_o), .second_accel_time_o(second_accel_time_o));
`default_nettype wire

// ### dicp_top_tb.sv
// Self-checking bench for the parameter bank against a register model.
// Assumes the master model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module dicp_top_tb;
    // ----------
    // Bench state and model
    // ----------
    logic clk = 1'b0, resetn = 1'b0, oreq = 1'b0, wr, rd, ack, err;
    logic [15:0] addr, wdata, rdata, fo, ep, sf, fs = 16'h0000;
    logic [15:0] v [5] = '{default: 16'h0000};
    logic [31:0] calc, acc2;
    logic [17:0] r;
    int num_errors = 0, checked = 0, i, e, m [13];
    int tv [3] = '{12345, 9999, 10007};
    localparam logic [15:0] ADR [13] = '{16'h1083, 16'h1084, 16'h1085, 16'h108E,
        16'h108F, 16'h1090, 16'h1091, 16'h1093, 16'h1095, 16'h1097, 16'h1098, 16'h1099, 16'h109A};
    localparam int MX [13] = '{100, 100, 1, 4, 4, 2, 4000, 1, 4000, 4000, 100, 100, 1};
    dicp_top uut (.core_clk_i(clk), .resetn_i(resetn), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err),
        .operator_val_i(v[0]), .pot_val_i(v[1]), .voltage_val_i(v[2]), .current_val_i(v[3]),
        .network_val_i(v[4]), .freq_set_i(fs), .offset_req_i(oreq), .freq_out_o(fo),
        .calc_result_o(calc), .current_in_start_point_o(), .current_in_end_point_o(ep),
        .current_in_zero_below_start_o(), .pot_start_frequency_o(sf), .pot_end_frequency_o(),
        .pot_start_point_o(), .pot_end_point_o(), .pot_start_freq_enable_o(),
        .second_accel_time_o(acc2), .second_decel_time_o());
    dicp_master net (.clk_i(clk), .ack_i(ack), .err_i(err), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [31:0] ex, sn, input string nm);
        checked++;
        if (sn !== ex) begin
            num_errors++;
            $display("unexpected %s: expected %0h seen %0h", nm, ex, sn);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic look(input int k);
        net.acc(1'b0, ADR[k], 16'h0000, r);
        chk(32'h20000 | m[k], 32'(r), "readback");
    endtask : look
    task automatic put(input int k, input int d);
        net.acc(1'b1, ADR[k], 16'(d), r);
        chk(d > MX[k] ? 1 : 2, 32'(r[17:16]), "write answer");
        if (d <= MX[k]) m[k] = d;
        look(k);
    endtask : put
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(87355));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (m[k]) begin
            m[k] = (k == 1 || k == 11) ? 100 : 0;
            look(k);
        end
        net.acc(1'b0, 16'h1092, 16'h0000, r);
        chk(32'h10000, 32'(r), "unmapped read");
        repeat (80) begin
            i = $urandom_range(12);
            put(i, $urandom_range(MX[i] + 3));
        end
        chk(32'(m[1]), 32'(ep), "end point out");
        chk(32'(m[8]), 32'(sf), "pot start out");
        // Pairs every source code with every operation code
        for (int k = 0; k < 15; k++) begin
            put(3, k % 5);
            put(4, (k / 3) % 5);
            put(5, k % 3);
            foreach (v[j]) v[j] <= 16'($urandom);
            repeat (2) @(posedge clk);
            e = m[5] == 0 ? v[m[3]] + v[m[4]] : m[5] == 1 ? v[m[3]] - v[m[4]] : v[m[3]] * v[m[4]];
            chk(32'(e), calc, "calc result");
        end
        for (int k = 0; k < 4; k++) begin
            put(6, $urandom_range(4000));
            put(7, k % 2);
            fs <= 16'($urandom_range(4000));
            oreq <= k < 3;
            repeat (4) @(posedge clk);
            e = !oreq ? fs : m[7] ? fs - m[6] : fs + m[6];
            e = e < 0 ? 0 : e > 4000 ? 4000 : e;
            chk(32'(e), 32'(fo), "offset freq");
        end
        foreach (tv[j]) begin
            net.acc(1'b1, 16'h1075, 16'(tv[j]), r);
            repeat (2) @(posedge clk);
            chk(tv[j] - (tv[j] >= 10000 ? tv[j] % 10 : 0), acc2, "accel time");
        end
        give_verdict();
    end
endmodule : dicp_top_tb
`default_nettype wire
